/* design/ppr_device.sv */
// Device end: power registers, input gating, reset sequencing.
// Assumes link pins are synchronous to clk_sys; nrst models supply power-up.
`timescale 1ns/1ps
`default_nettype none
module ppr_device
	import ppr_pkg::*;
#(
	parameter int WARM_CYC = WARM_PULSE_CYC,
	parameter int POR_CYC  = POR_PULSE_CYC,
	parameter int OPR_CYC  = OPR_WAIT_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	ppr_link_if.device      link,
	input  wire logic [1:0] ext_addr,
	input  wire logic       pd0_in,
	input  wire logic       pc7_in,
	input  wire logic       ext_clk_in,
	input  wire logic [7:0] mcell_d,
	output logic [7:0]      pwr_zero,
	output logic [7:0]      pwr_two,
	output logic [4:0]      array_ctl,
	output logic            array_clk,
	output logic            mcell_clk,
	output logic [1:0]      array_addr,
	output logic            fast_mode,
	output logic            flash_wr_n,
	output logic            flash_rd_n,
	output logic            flash_en,
	output logic            flash_read_array,
	output logic [7:0]      mcell_q,
	output logic            port_dir_out,
	output logic            pld_valid,
	output logic            in_reset
);
	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_HOLD    = 2'b10,
		ST_WAIT    = 2'b01,
		ST_RUN     = 2'b11
	} ppr_state_t;

	ppr_state_t  state_r;
	logic [15:0] cnt_r;
	logic        cfg_done_r;
	logic [7:0]  pwr_zero_r;
	logic [7:0]  pwr_two_r;
	logic        host_rst;
	logic        wr_ev;

	assign host_rst = !link.rst_n;
	assign wr_ev    = !link.wr_n && !link.cs_n && state_r == ST_RUN;

	// ==========================================
	// Reset sequencer
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_r <= ST_POWERUP;
			cnt_r   <= 16'h0000;
		end else begin
			case (state_r)
				ST_POWERUP: begin
					// Config load runs only while the power-on pulse is held
					if (!host_rst && cfg_done_r && cnt_r >= 16'(POR_CYC)) begin
						state_r <= ST_WAIT;
						cnt_r   <= 16'h0000;
					end else if (host_rst) begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				ST_HOLD: begin
					if (!host_rst) begin
						state_r <= ST_WAIT;
						cnt_r   <= 16'h0000;
					end
				end
				ST_WAIT: begin
					if (host_rst) begin
						state_r <= ST_HOLD;
					end else if (cnt_r >= 16'(OPR_CYC - 1)) begin
						state_r <= ST_RUN;
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				ST_RUN: begin
					if (host_rst) begin
						state_r <= ST_HOLD;
					end
				end
				default: state_r <= ST_POWERUP;
			endcase
		end
	end

	// Configuration bits load early in the power-on pulse
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cfg_done_r <= 1'b0;
		end else if (state_r == ST_POWERUP && host_rst && cnt_r >= 16'(CFG_LOAD_CYC - 1)) begin
			cfg_done_r <= 1'b1;
		end
	end

	// ==========================================
	// Power registers: cleared by power-up only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pwr_zero_r <= PWR_RST_VAL;
			pwr_two_r  <= PWR_RST_VAL;
		end else if (wr_ev) begin
			if (link.addr == ADDR_PWR_ZERO) begin
				pwr_zero_r <= link.wdata;
			end else if (link.addr == ADDR_PWR_TWO) begin
				pwr_two_r <= link.wdata;
			end
		end
	end

	// ==========================================
	// Input gating, registered from the stored bits and, for array_addr, the pdown pin
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			array_ctl  <= 5'h00;
			array_clk  <= 1'b0;
			mcell_clk  <= 1'b0;
			array_addr <= 2'h0;
			fast_mode  <= 1'b1;
		end else begin
			array_ctl[0] <= !link.wr_n  && !pwr_two_r[BIT_BLK_CS0];
			array_ctl[1] <= !link.rd_n  && !pwr_two_r[BIT_BLK_CS1];
			array_ctl[2] <= link.control_strobe_2  && !pwr_two_r[BIT_BLK_CS2];
			array_ctl[3] <= pd0_in      && !pwr_two_r[BIT_BLK_PD0];
			array_ctl[4] <= pc7_in      && !pwr_two_r[BIT_BLK_PC7];
			array_clk    <= ext_clk_in  && !pwr_zero_r[BIT_CLK_ARRAY];
			mcell_clk    <= ext_clk_in  && !pwr_zero_r[BIT_CLK_MCELL];
			array_addr   <= link.pdown ? 2'h0 : ext_addr;
			fast_mode    <= !pwr_zero_r[BIT_SPEED_OFF];
		end
	end

	// ==========================================
	// Flash path: strobes bypass every blocking bit
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flash_wr_n       <= 1'b1;
			flash_rd_n       <= 1'b1;
			flash_en         <= 1'b0;
			flash_read_array <= 1'b1;
		end else begin
			flash_wr_n       <= link.wr_n || link.cs_n;
			flash_rd_n       <= link.rd_n || link.cs_n;
			flash_en         <= !link.cs_n;
			flash_read_array <= flash_read_array || state_r == ST_POWERUP;
		end
	end

	// ==========================================
	// Macrocells, ports and other state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mcell_q <= 8'h00;
		end else if (state_r != ST_POWERUP && mcell_clk) begin
			mcell_q <= mcell_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			port_dir_out <= 1'b0;
		end else if (host_rst) begin
			port_dir_out <= 1'b0;
		end else if (state_r == ST_RUN && !link.pdown && !link.rd_n && !link.cs_n) begin
			// Leaving input mode only once running; power-down holds it
			port_dir_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pld_valid <= 1'b0;
			in_reset  <= 1'b1;
			pwr_zero  <= 8'h00;
			pwr_two   <= 8'h00;
		end else begin
			pld_valid <= cfg_done_r || state_r != ST_POWERUP;
			in_reset  <= state_r != ST_RUN;
			pwr_zero  <= pwr_zero_r;
			pwr_two   <= pwr_two_r;
		end
	end

	assign link.busy = in_reset;
endmodule
`default_nettype wire

/* design/ppr_host.sv */
// Host end: drives reset pulses and writes power registers on command.
// Assumes a plain register port from software on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ppr_host
	import ppr_pkg::*;
#(
	parameter int WARM_CYC = WARM_PULSE_CYC,
	parameter int POR_CYC  = POR_PULSE_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	ppr_link_if.host        link,
	input  wire logic [2:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic [7:0]      sw_rdata
);
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_RST   = 2'b01,
		HS_WRITE = 2'b10
	} ppr_hstate_t;

	ppr_hstate_t hstate_r;
	logic [15:0] hcnt_r;
	logic        csel_r;
	logic        pdown_r;
	logic        por_done_r;
	logic [7:0]  pw0_r;
	logic [7:0]  pw2_r;
	logic        pend0_r;
	logic        pend2_r;
	logic        launch;

	// Go commands win over a pending write in the same cycle
	assign launch = hstate_r == HS_IDLE && !link.busy && (pend0_r || pend2_r)
		&& !(sw_wr && sw_addr == HADDR_CTRL
		&& (sw_wdata[HBIT_GO_POR] || sw_wdata[HBIT_GO_WARM]));

	// ==========================================
	// Software command registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			csel_r  <= 1'b0;
			pdown_r <= 1'b0;
			pw0_r   <= DATA_ZERO;
			pw2_r   <= DATA_ZERO;
			pend0_r <= 1'b0;
			pend2_r <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == HADDR_CTRL) begin
				pdown_r <= sw_wdata[HBIT_PDOWN];
				csel_r  <= sw_wdata[HBIT_CSEL];
			end
			// New request wins over the clear of a finished one
			if (sw_wr && sw_addr == HADDR_PWR0) begin
				pw0_r   <= sw_wdata;
				pend0_r <= 1'b1;
			end else if (launch && pend0_r) begin
				pend0_r <= 1'b0;
			end
			if (sw_wr && sw_addr == HADDR_PWR2) begin
				pw2_r   <= sw_wdata & PWR_TWO_USED;
				pend2_r <= 1'b1;
			end else if (launch && !pend0_r && pend2_r) begin
				pend2_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sw_rdata <= DATA_ZERO;
		end else if (sw_rd) begin
			case (sw_addr)
				HADDR_CTRL:   sw_rdata <= {4'h0, csel_r, pdown_r, 2'b00};
				HADDR_STATUS: sw_rdata <= {5'h00, pend2_r | pend0_r, hstate_r == HS_RST,
					link.busy};
				HADDR_PWR0:   sw_rdata <= pw0_r;
				HADDR_PWR2:   sw_rdata <= pw2_r;
				default:      sw_rdata <= DATA_ZERO;
			endcase
		end else begin
			sw_rdata <= DATA_ZERO;
		end
	end

	// ==========================================
	// Link sequencer
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			hstate_r   <= HS_RST;
			hcnt_r     <= 16'h0000;
			por_done_r <= 1'b0;
		end else begin
			case (hstate_r)
				HS_IDLE: begin
					if (sw_wr && sw_addr == HADDR_CTRL && sw_wdata[HBIT_GO_POR]) begin
						hstate_r   <= HS_RST;
						por_done_r <= 1'b0;
						hcnt_r     <= 16'h0000;
					end else if (sw_wr && sw_addr == HADDR_CTRL && sw_wdata[HBIT_GO_WARM]) begin
						hstate_r <= HS_RST;
						hcnt_r   <= 16'h0000;
					end else if (launch) begin
						hstate_r <= HS_WRITE;
					end
				end
				HS_RST: begin
					if (hcnt_r >= 16'(por_done_r ? WARM_CYC - 1 : POR_CYC - 1)) begin
						hstate_r   <= HS_IDLE;
						por_done_r <= 1'b1;
					end else begin
						hcnt_r <= hcnt_r + 16'h0001;
					end
				end
				HS_WRITE: hstate_r <= HS_IDLE;
				default:  hstate_r <= HS_IDLE;
			endcase
		end
	end

	// ==========================================
	// Pin drivers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			link.rst_n <= 1'b0;
			link.wr_n  <= 1'b1;
			link.rd_n  <= 1'b1;
			link.control_strobe_2 <= 1'b0;
			link.cs_n  <= 1'b1;
			link.pdown <= 1'b0;
			link.addr  <= 2'h0;
			link.wdata <= DATA_ZERO;
		end else begin
			// Low for every counted cycle, so the pulse has its full length
			link.rst_n <= !(hstate_r == HS_RST);
			link.wr_n  <= !launch;
			link.cs_n  <= !(csel_r || launch) || hstate_r == HS_RST;
			link.pdown <= pdown_r;
			link.addr  <= pend0_r ? ADDR_PWR_ZERO : ADDR_PWR_TWO;
			link.wdata <= pend0_r ? pw0_r : pw2_r;
		end
	end
endmodule
`default_nettype wire

/* design/ppr_link_if.sv */
// Interface: the pins between the host and the power and reset device.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface ppr_link_if;
	logic       rst_n;
	logic       wr_n;
	logic       rd_n;
	logic       control_strobe_2;
	logic       cs_n;
	logic       pdown;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       busy;
	modport host (output rst_n, output wr_n, output rd_n, output control_strobe_2, output cs_n,
		output pdown, output addr, output wdata, input busy);
	modport device (input rst_n, input wr_n, input rd_n, input control_strobe_2, input cs_n,
		input pdown, input addr, input wdata, output busy);
endinterface
`default_nettype wire

/* design/ppr_pkg.sv */
// Package: constants shared by both ends of the power and reset link.
// Assumes a single 10 MHz system clock on both ends.
package ppr_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int POR_PULSE_NS    = 1000;
	localparam int WARM_PULSE_NS   = 300;
	localparam int OPR_WAIT_NS     = 2000;
	localparam int POR_PULSE_CYC   = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WARM_PULSE_CYC  = (WARM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OPR_WAIT_CYC    = (OPR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CFG_LOAD_CYC    = 4;
	// ==========================================
	// Device register map (over the link)
	localparam logic [1:0] ADDR_PWR_ZERO = 2'h0;
	localparam logic [1:0] ADDR_PWR_TWO  = 2'h2;
	localparam logic [7:0] PWR_RST_VAL   = 8'h00;
	localparam int BIT_SPEED_OFF  = 3;
	localparam int BIT_CLK_ARRAY  = 4;
	localparam int BIT_CLK_MCELL  = 5;
	localparam int BIT_BLK_CS0    = 2;
	localparam int BIT_BLK_CS1    = 3;
	localparam int BIT_BLK_CS2    = 4;
	localparam int BIT_BLK_PD0    = 5;
	localparam int BIT_BLK_PC7    = 6;
	localparam logic [7:0] PWR_TWO_USED = 8'h7c;
	// ==========================================
	// Host command registers
	localparam logic [2:0] HADDR_CTRL   = 3'h0;
	localparam logic [2:0] HADDR_STATUS = 3'h1;
	localparam logic [2:0] HADDR_PWR0   = 3'h2;
	localparam logic [2:0] HADDR_PWR2   = 3'h3;
	localparam int HBIT_GO_POR  = 0;
	localparam int HBIT_GO_WARM = 1;
	localparam int HBIT_PDOWN   = 2;
	localparam int HBIT_CSEL    = 3;
	localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

/* testbench/pld_power_reset_control_tb.sv */
// Bench: host and device joined by the link, driven from the software port.
// Assumes the package defaults for pulse and wait lengths.
`timescale 1ns/1ps
`default_nettype none
module pld_power_reset_control_tb;
	import ppr_pkg::*;
	logic        clk_sys, nrst, sw_wr, sw_rd, pd0_in, pc7_in, ext_clk_in;
	logic        array_clk, mcell_clk, fast_mode, flash_wr_n, flash_rd_n, flash_en;
	logic        read_array, port_dir_out, pld_valid, in_reset;
	logic [2:0]  sw_addr;
	logic [1:0]  ext_addr, array_addr;
	logic [4:0]  array_ctl;
	logic [7:0]  sw_wdata, sw_rdata, mcell_d, pwr_zero, pwr_two, mcell_q;
	logic [31:0] seed, r;
	int          m0, m2, m2p, pdn, csl, n_errors, checked;
	ppr_link_if link ();
	ppr_host ppr_host_i (.clk_sys(clk_sys), .nrst(nrst), .link(link.host), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	ppr_device ppr_device_i (.clk_sys(clk_sys), .nrst(nrst), .link(link.device),
		.ext_addr(ext_addr), .pd0_in(pd0_in), .pc7_in(pc7_in), .ext_clk_in(ext_clk_in),
		.mcell_d(mcell_d), .pwr_zero(pwr_zero), .pwr_two(pwr_two), .array_ctl(array_ctl),
		.array_clk(array_clk), .mcell_clk(mcell_clk), .array_addr(array_addr),
		.fast_mode(fast_mode), .flash_wr_n(flash_wr_n), .flash_rd_n(flash_rd_n),
		.flash_en(flash_en),
		.flash_read_array(read_array), .mcell_q(mcell_q), .port_dir_out(port_dir_out),
		.pld_valid(pld_valid), .in_reset(in_reset));
	ppr_link_properties ppr_link_properties_i (.clk_sys(clk_sys), .nrst(nrst),
		.rst_n(link.rst_n), .wr_n(link.wr_n), .rd_n(link.rd_n), .control_strobe_2(link.control_strobe_2),
		.cs_n(link.cs_n), .pdown(link.pdown), .addr(link.addr), .wdata(link.wdata),
		.busy(link.busy));
	// ==========================================
	// Clock and helpers
	initial begin
		clk_sys = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk_sys);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_sys);
		sw_rd <= 1'b0;
		#1;
		chk("sw_rdata", exp, sw_rdata);
	endtask
	// Bounded: a device stuck in reset must not hang the run
	task automatic reset_wait();
		int k;
		k = 0;
		while (in_reset !== 1'b1 && k < 10) begin
			tick(1);
			k++;
		end
		while (link.busy !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		chk("busy", 8'h00, 8'(link.busy));
		tick(2);
	endtask
	// Flash always sees the strobe; the array copy only when not blocked
	task automatic strobe_seen(input logic blk);
		logic seen, ctl;
		seen = 1'b0;
		ctl = 1'b0;
		repeat (8) begin
			tick(1);
			if (flash_wr_n === 1'b0) seen = 1'b1;
			if (array_ctl[0] === 1'b1) ctl = 1'b1;
		end
		chk("flash_wr", 8'h01, 8'(seen));
		chk("ctl_wr", 8'(!blk), 8'(ctl));
	endtask
	task automatic check_all();
		chk("pwr_zero", 8'(m0), pwr_zero);
		chk("pwr_two", 8'(m2), pwr_two);
		chk("fast", 8'(!m0[3]), 8'(fast_mode));
		chk("array_clk", 8'(ext_clk_in & !m0[4]), 8'(array_clk));
		chk("mcell_clk", 8'(ext_clk_in & !m0[5]), 8'(mcell_clk));
		chk("ctl_control_strobe_2", 8'(link.control_strobe_2 & !m2[4]), 8'(array_ctl[2]));
		chk("ctl_pd0", 8'(pd0_in & !m2[5]), 8'(array_ctl[3]));
		chk("ctl_pc7", 8'(pc7_in & !m2[6]), 8'(array_ctl[4]));
		chk("array_addr", pdn ? 8'h00 : 8'(ext_addr), 8'(array_addr));
		chk("flash_en", 8'(csl[0]), 8'(flash_en));
		chk("cs_n", 8'(!csl[0]), 8'(link.cs_n));
		chk("flash_rd_n", 8'h01, 8'(flash_rd_n));
		chk("ctl_rd", 8'h00, 8'(array_ctl[1]));
		chk("port_dir", 8'h00, 8'(port_dir_out));
		chk("pld_valid", 8'h01, 8'(pld_valid));
		chk("read_array", 8'h01, 8'(read_array));
		if (ext_clk_in && !m0[5]) chk("mcell_q", mcell_d, mcell_q);
	endtask
	task automatic stop_test();
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#(4000 * CLK_PERIOD_NS);
		n_errors++;
		stop_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		seed = 32'h0000_4bd8;
		{n_errors, checked, m0, m2, m2p, pdn, csl} = '0;
		{nrst, sw_wr, sw_rd, pd0_in, pc7_in, ext_clk_in} = '0;
		{sw_addr, sw_wdata, ext_addr, mcell_d} = '0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		reset_wait();
		check_all();
		chk("mcell_q", 8'h00, mcell_q);
		sw_read(HADDR_STATUS, 8'h00);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			r = rnd();
			{mcell_d, ext_clk_in, pc7_in, pd0_in, ext_addr} <= {r[15:8], r[4:0]};
			pdn = int'(r[5]);
			csl = int'(r[6]);
			sw_write(HADDR_CTRL, {4'h0, r[6], r[5], 2'h0});
			m0 = int'(r[23:16] & 8'h38);
			sw_write(HADDR_PWR0, 8'(m0));
			m2p = m2;
			m2 = int'(r[31:24] & PWR_TWO_USED);
			sw_write(HADDR_PWR2, r[31:24]);
			strobe_seen(m2p[2]);
			check_all();
			sw_read(HADDR_PWR0, 8'(m0));
			sw_read(HADDR_PWR2, 8'(m2));
		end
		sw_write(HADDR_CTRL, 8'(1 << HBIT_GO_WARM));
		{pdn, csl} = '0;
		reset_wait();
		check_all();
		sw_write(HADDR_CTRL, 8'(1 << HBIT_GO_POR));
		reset_wait();
		check_all();
		@(posedge clk_sys);
		ext_clk_in <= 1'b0;
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		{m0, m2} = '0;
		reset_wait();
		check_all();
		chk("mcell_q", 8'h00, mcell_q);
		stop_test();
	end
endmodule
`default_nettype wire

/* testbench/ppr_link_properties.sv */
// Checker for the link between host and device ends.
// Assumes it sits beside the link interface, sharing clk_sys and nrst.
`timescale 1ns/1ps
`default_nettype none
module ppr_link_properties
	import ppr_pkg::*;
#(
	parameter int WARM_CYC = WARM_PULSE_CYC,
	parameter int POR_CYC  = POR_PULSE_CYC,
	parameter int OPR_CYC  = OPR_WAIT_CYC
) (
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic       rst_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       control_strobe_2,
	input wire logic       cs_n,
	input wire logic       pdown,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       busy
);
	// Slack for the config load that runs within a power-on pulse
	localparam int BUSY_MAX = OPR_CYC + CFG_LOAD_CYC + 4;
	logic [7:0] low_r;
	logic [7:0] rel_r;
	logic       first_r;
	// ==========================================
	// Cycle counters
	always_ff @(posedge clk_sys) begin
		if (!nrst || rst_n) begin
			low_r <= 8'h00;
		end else if (low_r != 8'hff) begin
			low_r <= low_r + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rel_r <= 8'h00;
		end else if (rel_r != 8'hff) begin
			rel_r <= rel_r + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			first_r <= 1'b1;
		end else if (rst_n) begin
			first_r <= 1'b0;
		end
	end
	// ==========================================
	// Properties
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_strobe_in_reset: assert property (!rst_n |-> wr_n)
		else $error("write strobe low in reset");
	a_select_in_reset: assert property (!rst_n |-> cs_n)
		else $error("select active in reset");
	a_unused_zero: assert property (
		!wr_n && !cs_n && addr == ADDR_PWR_TWO |-> (wdata & ~PWR_TWO_USED) == DATA_ZERO)
		else $error("unused bits written");
	a_write_selects: assert property (!wr_n |-> !cs_n)
		else $error("write without select");
	a_write_not_busy: assert property (!wr_n |-> rst_n && !busy)
		else $error("write during reset");
	a_busy_enter: assert property ($fell(rst_n) |-> ##[1:2] busy)
		else $error("busy missing after reset");
	a_busy_hold: assert property (rst_n && rel_r < OPR_CYC |-> busy)
		else $error("busy dropped early");
	a_busy_bound: assert property (rel_r > BUSY_MAX |-> !busy)
		else $error("busy held too long");
	a_por_width: assert property ($rose(rst_n) && first_r |-> low_r >= POR_CYC)
		else $error("power-on pulse short");
	a_warm_width: assert property ($rose(rst_n) |-> low_r >= WARM_CYC)
		else $error("warm pulse short");
endmodule
`default_nettype wire
